// file: common/rrs_pkg.sv
// Constants, register map and state type for the return/rotate/subtract execution unit
package rrs_pkg;
	localparam int          ADR_W        = 12;
	localparam int          DATA_AW      = 7;
	localparam int          DATA_REGS    = 128;
	localparam int          PC_W         = 11;
	localparam int          RETURN_CYCLES = 2;
	// Register byte addresses
	localparam logic [11:0] REG_CTRL     = 12'h000;
	localparam logic [11:0] REG_ACCUM    = 12'h004;
	localparam logic [11:0] REG_STATUS   = 12'h008;
	localparam logic [11:0] REG_PC       = 12'h00c;
	localparam logic [11:0] REG_TOS      = 12'h010;
	localparam logic [2:0]  DATA_BASE_HI = 3'h1;   // Data window 0x200..0x3fc
	// Command word fields
	localparam int          CTRL_OP_LSB  = 0;
	localparam int          CTRL_D_BIT   = 3;
	localparam int          CTRL_REG_LSB = 8;
	localparam int          CTRL_IMM_LSB = 16;
	// Status bits
	localparam int          ST_C         = 0;
	localparam int          ST_DIGIT     = 1;
	localparam int          ST_Z         = 2;
	localparam int          ST_BUSY      = 8;
	// Reset values
	localparam logic [7:0]  ACCUM_RST    = 8'h00;
	localparam logic [10:0] PC_RST       = 11'h000;
	// Command codes
	localparam logic [1:0]  OP_RETURN_FROM_CALL  = 2'h0;
	localparam logic [1:0]  OP_ROTATE_RIGHT      = 2'h1;
	localparam logic [1:0]  OP_SUB_BORROW_REG    = 2'h2;
	localparam logic [1:0]  OP_SUB_BORROW_IMM    = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_EXEC,
		ST_RETURN1,
		ST_RETURN2
	} rrs_state_t;
endpackage : rrs_pkg

// file: hw/rrs_exec.sv
// Execution unit for return, rotate-right-through-carry and subtract-with-borrow
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rrs_exec
	import rrs_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o
);
	// Address match, used for every register outside the data window
	function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] off);
		hit = (adr == off);
	endfunction : hit

	rrs_state_t        state;
	rrs_state_t        next_state;
	logic              bus_wait;
	logic [7:0]        accumulator;
	logic              flag_c;
	logic              digit_carry_flag;
	logic              flag_z;
	logic [PC_W-1:0]   pc;
	logic [PC_W-1:0]   tos;
	logic [1:0]        op;
	logic              op_d;
	logic [DATA_AW-1:0] op_reg;
	logic [7:0]        op_imm;
	logic [7:0]        mem_rdata;

	// Bus decode
	wire        busy    = (state != ST_IDLE);
	wire        bus_go  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~bus_wait & ~busy;
	wire        bus_wr  = bus_wait & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
	wire        is_data = (wb_adr_i[11:9] == DATA_BASE_HI) & (wb_adr_i[1:0] == 2'h0);
	wire        ctrl_wr = bus_wr & hit(wb_adr_i, REG_CTRL);
	wire [1:0]  new_op  = wb_dat_i[CTRL_OP_LSB +: 2];

	// Datapath
	wire        exec     = (state == ST_EXEC);
	wire        is_rot   = (op == OP_ROTATE_RIGHT);
	wire [7:0]  opnd     = (op == OP_SUB_BORROW_IMM) ? op_imm : mem_rdata;
	wire [8:0]  sum9     = {1'b0, opnd} + {1'b0, ~accumulator} + {8'h00, flag_c};
	wire [4:0]  sum5     = {1'b0, opnd[3:0]} + {1'b0, ~accumulator[3:0]} + {4'h0, flag_c};
	wire [7:0]  rot      = {flag_c, opnd[7:1]};
	wire [7:0]  res      = is_rot ? rot : sum9[7:0];
	wire        dest_accum = ~op_d | (op == OP_SUB_BORROW_IMM);
	wire        next_c     = is_rot ? opnd[0] : sum9[8];
	wire        next_nib   = sum5[4];
	wire        next_z   = (sum9[7:0] == 8'h00);

	// Single memory port: execution owns it while busy
	wire [DATA_AW-1:0] mem_addr  = busy ? op_reg : wb_adr_i[8:2];
	wire               mem_we    = (exec & ~dest_accum) | (bus_wr & is_data);
	wire [7:0]         mem_wdata = exec ? res : wb_dat_i[7:0];

	// Read mux
	wire [31:0] rd_mux =
		is_data                       ? {24'h000000, mem_rdata} :
		hit(wb_adr_i, REG_ACCUM)      ? {24'h000000, accumulator} :
		hit(wb_adr_i, REG_STATUS)     ? {23'h000000, busy, 5'h00, flag_z, digit_carry_flag, flag_c} :
		hit(wb_adr_i, REG_PC)         ? {21'h000000, pc} :
		hit(wb_adr_i, REG_TOS)        ? {21'h000000, tos} :
		hit(wb_adr_i, REG_CTRL)       ? {8'h00, op_imm, 1'b0, op_reg, 4'h0, op_d, 1'b0, op} :
		32'h00000000;

	rrs_regmem u_mem (
		.clk_i   (clk_i),
		.we_i    (mem_we),
		.addr_i  (mem_addr),
		.wdata_i (mem_wdata),
		.rdata_o (mem_rdata)
	);

	// Sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (ctrl_wr) begin
					case (new_op)
						OP_RETURN_FROM_CALL: next_state = ST_RETURN1;
						OP_SUB_BORROW_IMM:   next_state = ST_EXEC;
						default:             next_state = ST_FETCH;
					endcase
				end
			end
			ST_FETCH: next_state = ST_EXEC;
			ST_EXEC:  next_state = ST_IDLE;
			ST_RETURN1: next_state = ST_RETURN2;
			ST_RETURN2: next_state = ST_IDLE;
			default:  next_state = ST_IDLE;
		endcase
	end

	// State and bus handshake
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state    <= ST_IDLE;
			bus_wait <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			state    <= next_state;
			bus_wait <= bus_go;
			wb_ack_o <= bus_wait;
			if (bus_wait) begin
				wb_dat_o <= rd_mux;
			end
		end
	end

	// Latched command
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op     <= OP_RETURN_FROM_CALL;
			op_d   <= 1'b0;
			op_reg <= '0;
			op_imm <= 8'h00;
		end else if (ctrl_wr) begin
			op     <= new_op;
			op_d   <= wb_dat_i[CTRL_D_BIT];
			op_reg <= wb_sel_i[1] ? wb_dat_i[CTRL_REG_LSB +: DATA_AW] : '0;
			op_imm <= wb_sel_i[2] ? wb_dat_i[CTRL_IMM_LSB +: 8] : 8'h00;
		end
	end

	// Accumulator
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			accumulator <= ACCUM_RST;
		end else if (exec & dest_accum) begin
			accumulator <= res;
		end else if (bus_wr & hit(wb_adr_i, REG_ACCUM)) begin
			accumulator <= wb_dat_i[7:0];
		end
	end

	// Flags: rotate touches carry only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_c           <= 1'b0;
			digit_carry_flag <= 1'b0;
			flag_z           <= 1'b0;
		end else if (exec) begin
			flag_c <= next_c;
			if (!is_rot) begin
				digit_carry_flag <= next_nib;
				flag_z           <= next_z;
			end
		end else if (bus_wr & hit(wb_adr_i, REG_STATUS)) begin
			flag_c           <= wb_dat_i[ST_C];
			digit_carry_flag <= wb_dat_i[ST_DIGIT];
			flag_z           <= wb_dat_i[ST_Z];
		end
	end

	// Program counter and stack top
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc  <= PC_RST;
			tos <= PC_RST;
		end else begin
			if (state == ST_RETURN2) begin
				pc <= tos;
			end else if (bus_wr & hit(wb_adr_i, REG_PC)) begin
				pc <= wb_dat_i[PC_W-1:0];
			end
			if (bus_wr & hit(wb_adr_i, REG_TOS)) begin
				tos <= wb_dat_i[PC_W-1:0];
			end
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence return_start;
		(state == ST_IDLE) && ctrl_wr && (new_op == OP_RETURN_FROM_CALL);
	endsequence

	sequence return_done;
		(state == ST_RETURN1) ##1 (state == ST_RETURN2) ##1 (state == ST_IDLE);
	endsequence

	a_return_two_cycles: assert property (return_start |=> return_done)
		else $error("return did not take two cycles");

	a_return_loads_pc: assert property ((state == ST_RETURN2) |=> (pc == $past(tos))
		&& $stable(flag_c) && $stable(flag_z) && $stable(digit_carry_flag))
		else $error("return pc or flags wrong");

	a_rot_result: assert property ((exec && is_rot && dest_accum) |=>
		(accumulator == {$past(flag_c), $past(mem_rdata[7:1])})
		&& (flag_c == $past(mem_rdata[0])))
		else $error("rotate result wrong");

	a_rot_flags_only: assert property ((exec && is_rot) |=>
		$stable(flag_z) && $stable(digit_carry_flag) && (state == ST_IDLE))
		else $error("rotate touched other flags");

	a_sub_reg_dest: assert property ((exec && (op == OP_SUB_BORROW_REG) && op_d) |->
		mem_we && (mem_addr == op_reg)
		&& (mem_wdata == 8'(mem_rdata - accumulator - {7'h00, ~flag_c})))
		else $error("register subtract writeback wrong");

	a_sub_imm_acc: assert property ((exec && (op == OP_SUB_BORROW_IMM)) |=>
		accumulator == 8'($past(op_imm) - $past(accumulator) - {7'h00, ~$past(flag_c)}))
		else $error("immediate subtract result wrong");

	a_sub_flags: assert property ((exec && !is_rot) |=>
		(flag_z == (8'($past(opnd) - $past(accumulator) - {7'h00, ~$past(flag_c)}) == 8'h00))
		&& (flag_c == ($past({1'b0, opnd}) >= $past({1'b0, accumulator}) + $past({8'h00, ~flag_c})))
		&& (digit_carry_flag == ($past({1'b0, opnd[3:0]})
			>= $past({1'b0, accumulator[3:0]}) + $past({4'h0, ~flag_c}))))
		else $error("subtract flags wrong");
endmodule : rrs_exec
`default_nettype wire

// file: hw/rrs_regmem.sv
// Data register file, 128 bytes, one port with registered read data
`timescale 1ns/1ps
`default_nettype none
module rrs_regmem
	import rrs_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               we_i,
	input  wire logic [DATA_AW-1:0] addr_i,
	input  wire logic [7:0]         wdata_i,
	output logic      [7:0]         rdata_o
);
	logic [7:0] mem [DATA_REGS];

	// Write first-less port: read shows the old contents
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end
endmodule : rrs_regmem
`default_nettype wire

// file: testbench/rrs_exec_test.sv
// Self-checking bench for the return/rotate/subtract execution unit
`timescale 1ns/1ps
`default_nettype none
module rrs_exec_test import rrs_pkg::*;;
	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             wb_cyc_i = 1'b0;
	logic             wb_stb_i = 1'b0;
	logic             wb_we_i = 1'b0;
	logic [ADR_W-1:0] wb_adr_i = '0;
	logic [3:0]       wb_sel_i = 4'hf;
	logic [31:0]      wb_dat_i = '0;
	logic [31:0]      wb_dat_o;
	logic             wb_ack_o;
	logic [31:0]      exp_q[$];
	logic [10:0]      pc_m = 11'h000;
	logic [31:0]      r;
	integer           seed = 32'h0ce31c16;
	int               n_mismatch = 0;
	int               cmp_count = 0;

	rrs_exec dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

	// Clock, 40 ns period
	initial forever #20 clk_i = ~clk_i;

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// Read data against the oldest expectation
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
			chk(exp_q.pop_front(), wb_dat_o);
	end

	// Classic single cycle; reads note d as the expected data
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		t = 0;
		if (!w)
			exp_q.push_back(d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= w ? d : $random(seed);
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 200);
		// An answer that never comes ends the run as a failure
		if (wb_ack_o !== 1'b1) begin
			n_mismatch++;
			end_of_test();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	// Set up operands, issue one command, read back every result
	task automatic run(input logic [1:0] op, input logic d, input logic [6:0] n,
		input logic [7:0] v, input logic [7:0] accum, input logic [7:0] imm, input logic [2:0] st);
		logic [7:0]  src;
		logic [8:0]  sum;
		logic [4:0]  lo;
		logic [7:0]  res;
		logic [7:0]  ea;
		logic [2:0]  nst;
		logic [10:0] tos;
		logic        tr;
		tos = 11'($random(seed));
		src = (op == OP_SUB_BORROW_IMM) ? imm : v;
		sum = {1'b0, src} + {1'b0, ~accum} + 9'(st[0]);
		lo = {1'b0, src[3:0]} + {1'b0, ~accum[3:0]} + 5'(st[0]);
		res = (op == OP_ROTATE_RIGHT) ? {st[0], v[7:1]} : sum[7:0];
		nst = (op == OP_ROTATE_RIGHT) ? {st[2:1], v[0]} : {sum[7:0] == 8'h00, lo[4], sum[8]};
		tr = d && (op == OP_ROTATE_RIGHT || op == OP_SUB_BORROW_REG);
		ea = tr ? accum : res;
		if (op == OP_RETURN_FROM_CALL) begin
			nst = st;
			ea = accum;
			pc_m = tos;
		end
		bus(1'b1, 12'h200 + {3'h0, n, 2'b00}, {24'h0, v});
		bus(1'b1, REG_ACCUM, {24'h0, accum});
		bus(1'b1, REG_STATUS, {29'h0, st});
		bus(1'b1, REG_TOS, {21'h0, tos});
		bus(1'b1, REG_CTRL, {8'h00, imm, 1'b0, n, 4'h0, d, 1'b0, op});
		bus(1'b0, REG_ACCUM, {24'h0, ea});
		bus(1'b0, 12'h200 + {3'h0, n, 2'b00}, {24'h0, tr ? res : v});
		bus(1'b0, REG_STATUS, {29'h0, nst});
		bus(1'b0, REG_PC, {21'h0, pc_m});
	endtask : run

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	// Main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(1'b0, REG_PC, 32'h0);
		bus(1'b0, 12'h100, 32'h0);
		wb_sel_i <= 4'he;
		bus(1'b1, REG_ACCUM, 32'h55);
		wb_sel_i <= 4'hf;
		bus(1'b0, REG_ACCUM, 32'h0);
		$display("test reset and refusal done");
		run(OP_ROTATE_RIGHT, 1'b1, 7'd127, 8'ha5, 8'h00, 8'h00, 3'h0);
		run(OP_SUB_BORROW_REG, 1'b1, 7'd0, 8'h05, 8'h06, 8'h00, 3'h0);
		run(OP_SUB_BORROW_IMM, 1'b1, 7'd9, 8'h00, 8'h05, 8'h06, 3'h0);
		run(OP_SUB_BORROW_IMM, 1'b0, 7'd1, 8'h00, 8'h00, 8'hff, 3'h7);
		$display("test worked examples done");
		for (int i = 0; i < 48; i++) begin
			r = $random(seed);
			run(2'(i), r[0], r[7:1], r[15:8], r[23:16], r[31:24], 3'($random(seed)));
		end
		$display("test random commands done");
		// Reset in mid-run: every register outside the data window returns to its reset value
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(1'b0, REG_ACCUM, {24'h0, ACCUM_RST});
		bus(1'b0, REG_STATUS, 32'h0);
		bus(1'b0, REG_PC, {21'h0, PC_RST});
		bus(1'b0, REG_TOS, {21'h0, PC_RST});
		bus(1'b0, REG_CTRL, 32'h0);
		$display("test mid-run reset done");
		end_of_test();
	end

	// Cut a hang short
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		end_of_test();
	end
endmodule : rrs_exec_test
`default_nettype wire
